//--- dcl_pkg.sv
// Package with register map, field layout and state types of the comparator logic unit.
`default_nettype none
package dcl_pkg;

  // Address width of the register bus and number of comparator channels.
  localparam int APB_AW = 12;
  localparam int CH_N = 2;

  // Register indices; the byte address of each is four times its index.
  localparam logic [APB_AW-3:0] IDX_READ_CLEAR = 10'h078;
  localparam logic [APB_AW-3:0] IDX_INPUT_SELECT = 10'h079;
  localparam logic [APB_AW-3:0] IDX_ENABLE_CONTROL = 10'h07a;
  localparam logic [APB_AW-3:0] IDX_OUTPUT_CONTROL = 10'h07b;
  localparam logic [APB_AW-3:0] IDX_FUNCTION_SELECT = 10'h07c;

  // Reset values of the stored registers.
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_ENABLE_CONTROL = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h00;
  localparam logic [7:0] RST_FUNCTION_SELECT = 8'h00;

  // Each channel owns one nibble; channel 1 sits four bits above channel 0.
  localparam int CH_STRIDE = 4;

  // Field positions inside the read/clear register.
  localparam int POS_LATCHED = 0;
  localparam int POS_LIVE = 4;

  // Field positions inside the channel nibble of the enable register.
  localparam int POS_ENABLE = 0;
  localparam logic [7:0] MASK_ENABLE_CONTROL = 8'h11;

  // Field positions inside the channel nibble of the output control register.
  localparam int POS_MAIN_SEL = 0;
  localparam int POS_CLEAR_SEL = 1;
  localparam int POS_PIN_SEL = 2;
  localparam int POS_ANALOG = 3;

  // Field positions inside the channel nibble of the input select register.
  localparam int POS_NEG_SRC = 0;
  localparam int POS_POS_SRC = 2;

  // Configuration carried out to the analog comparators.
  typedef struct packed {
    logic [CH_N-1:0] enable;
    logic [CH_N-1:0] analog_out_connect;
    logic [1:0] positive_source_ch1;
    logic [1:0] negative_source_ch1;
    logic [1:0] positive_source_ch0;
    logic [1:0] negative_source_ch0;
  } dcl_ana_cfg_t;

  // Complete state of the unit.
  typedef struct packed {
    logic [7:0] input_select;
    logic [7:0] enable_control;
    logic [7:0] output_control;
    logic [7:0] function_select;
    logic [CH_N-1:0] sync_a;
    logic [CH_N-1:0] sync_b;
    logic [CH_N-1:0] lut_prev;
    logic [CH_N-1:0] latched;
    logic [CH_N-1:0] main_out;
    logic [CH_N-1:0] pin_out;
    logic [31:0] prdata;
  } dcl_state_t;

endpackage : dcl_pkg
`default_nettype wire

//--- dcl_unit.sv
// Comparator digital interface: lookup functions, latches, output routing, APB.
`timescale 1ns/1ps
`default_nettype none

module dcl_unit (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dcl_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dcl_pkg::CH_N-1:0] cmp_raw,
  output dcl_pkg::dcl_ana_cfg_t ana_cfg,
  output logic [dcl_pkg::CH_N-1:0] main_out,
  output logic [dcl_pkg::CH_N-1:0] pin_out
);
  import dcl_pkg::*;

  dcl_state_t s_q;
  dcl_state_t s_d;

  logic [APB_AW-3:0] word_idx;
  logic hit_rdc;
  logic hit_mux;
  logic hit_en;
  logic hit_out;
  logic hit_fn;
  logic mapped;
  logic setup;
  logic wr_acc;
  logic wr_rdc;
  logic [CH_N-1:0] live;
  logic [CH_N-1:0] lut;
  logic [CH_N-1:0] rise;
  logic [CH_N-1:0] clr;
  logic [CH_N-1:0] main_d;
  logic [CH_N-1:0] pin_d;
  logic [7:0] rdc_view;

  // Address decode of the word-aligned register window.
  assign word_idx = paddr[APB_AW-1:2];
  assign hit_rdc = (word_idx == IDX_READ_CLEAR);
  assign hit_mux = (word_idx == IDX_INPUT_SELECT);
  assign hit_en = (word_idx == IDX_ENABLE_CONTROL);
  assign hit_out = (word_idx == IDX_OUTPUT_CONTROL);
  assign hit_fn = (word_idx == IDX_FUNCTION_SELECT);
  assign mapped = hit_rdc | hit_mux | hit_en | hit_out | hit_fn;

  // Bus phases; every access completes in its first access cycle.
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pstrb[0] & mapped;
  assign wr_rdc = wr_acc & hit_rdc;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Per-channel lookup, edge detection, clear source and output selection.
  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    logic [3:0] code;
    logic own_in;
    logic other_in;
    // A disabled comparator reads as a constant low.
    assign live[i] = s_q.sync_b[i] & s_q.enable_control[CH_STRIDE*i+POS_ENABLE];
    assign code = s_q.function_select[CH_STRIDE*i +: 4];
    assign own_in = live[i];
    assign other_in = live[CH_N-1-i];
    assign lut[i] = code[{other_in, own_in}];
    assign rise[i] = lut[i] & ~s_q.lut_prev[i];
    // Clear by the other channel's rising edge, or by a zero written to the bit.
    assign clr[i] = s_q.output_control[CH_STRIDE*i+POS_CLEAR_SEL] ?
                    rise[CH_N-1-i] : (wr_rdc & ~pwdata[POS_LATCHED+i]);
    assign main_d[i] = s_q.output_control[CH_STRIDE*i+POS_MAIN_SEL] ?
                       s_q.latched[i] : lut[i];
    assign pin_d[i] = s_q.output_control[CH_STRIDE*i+POS_PIN_SEL] ?
                      s_q.latched[i] : lut[i];
    assign ana_cfg.analog_out_connect[i] =
      s_q.output_control[CH_STRIDE*i+POS_ANALOG];
    assign ana_cfg.enable[i] =
      s_q.enable_control[CH_STRIDE*i+POS_ENABLE];
  end

  // Source selects go straight to the analog input multiplexers.
  assign ana_cfg.positive_source_ch1 =
    s_q.input_select[CH_STRIDE+POS_POS_SRC +: 2];
  assign ana_cfg.negative_source_ch1 =
    s_q.input_select[CH_STRIDE+POS_NEG_SRC +: 2];
  assign ana_cfg.positive_source_ch0 = s_q.input_select[POS_POS_SRC +: 2];
  assign ana_cfg.negative_source_ch0 = s_q.input_select[POS_NEG_SRC +: 2];

  // Read view of the read/clear register; other bits read as zero.
  always_comb begin
    rdc_view = 8'h00;
    rdc_view[POS_LIVE +: CH_N] = live;
    rdc_view[POS_LATCHED +: CH_N] = s_q.latched;
  end

  // Next-state logic of the whole unit.
  always_comb begin
    s_d = s_q;
    // Comparator outputs are asynchronous and pass two flip-flops.
    s_d.sync_a = cmp_raw;
    s_d.sync_b = s_q.sync_a;
    s_d.lut_prev = lut;
    // Set beats clear, so an event in a clear cycle is never lost.
    s_d.latched = (s_q.latched & ~clr) | lut;
    s_d.main_out = main_d;
    s_d.pin_out = pin_d;
    // Register writes land on the completing access edge; reserved bits drop.
    if (wr_acc && hit_mux) begin
      s_d.input_select = pwdata[7:0];
    end
    if (wr_acc && hit_en) begin
      s_d.enable_control = pwdata[7:0] & MASK_ENABLE_CONTROL;
    end
    if (wr_acc && hit_out) begin
      s_d.output_control = pwdata[7:0];
    end
    if (wr_acc && hit_fn) begin
      s_d.function_select = pwdata[7:0];
    end
    // Read data is captured in the setup cycle and held through the access.
    if (setup) begin
      case (1'b1)
        hit_rdc: s_d.prdata = {24'h000000, rdc_view};
        hit_mux: s_d.prdata = {24'h000000, s_q.input_select};
        hit_en: s_d.prdata = {24'h000000, s_q.enable_control};
        hit_out: s_d.prdata = {24'h000000, s_q.output_control};
        hit_fn: s_d.prdata = {24'h000000, s_q.function_select};
        default: s_d.prdata = 32'h00000000;
      endcase
    end
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.input_select <= RST_INPUT_SELECT;
      s_q.enable_control <= RST_ENABLE_CONTROL;
      s_q.output_control <= RST_OUTPUT_CONTROL;
      s_q.function_select <= RST_FUNCTION_SELECT;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign prdata = s_q.prdata;
  assign main_out = s_q.main_out;
  assign pin_out = s_q.pin_out;

  // Checks on the unit's own behaviour.
  default clocking dcl_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic rd_setup_rdc;
  logic wr0_clear;
  assign rd_setup_rdc = setup & ~pwrite & hit_rdc;
  assign wr0_clear = wr_rdc & ~pwdata[POS_LATCHED] &
                     ~s_q.output_control[POS_CLEAR_SEL];

  // A high lookup output is in the latch one cycle later.
  AST_SET_LATCH: assert property (lut[0] |=> s_q.latched[0])
    else $error("Latch 0 not set after high lookup output.");

  // Live main output of channel 0 follows its code indexed by both results.
  AST_MAIN_LIVE: assert property (
    !s_q.output_control[POS_MAIN_SEL] |=>
      main_out[0] == $past(s_q.function_select[{live[1], live[0]}]))
    else $error("Main output 0 does not follow the lookup function.");

  // Channel 1 code picks its bit by {comparator 0, comparator 1}.
  AST_NEIGHBOR: assert property (
    (live == 2'b01 && !s_q.output_control[CH_STRIDE+POS_MAIN_SEL]) |=>
      main_out[1] == $past(s_q.function_select[CH_STRIDE+2]))
    else $error("Channel 1 lookup does not take comparator 0 as other input.");

  // An edge clear empties the latch unless a set arrives together.
  AST_EDGE_CLEAR: assert property (
    (s_q.output_control[POS_CLEAR_SEL] && rise[1] && !lut[0]) |=>
      !s_q.latched[0])
    else $error("Latch 0 not cleared by rising edge of channel 1.");

  // A written zero clears the latch in write-clear mode.
  AST_WRITE_CLEAR: assert property (wr0_clear && !lut[0] |=> !s_q.latched[0])
    else $error("Latch 0 not cleared by register write.");

  // Without a clear the latch stays high.
  AST_HOLD: assert property (s_q.latched[1] && !clr[1] |=> s_q.latched[1])
    else $error("Latch 1 dropped without a clear.");

  // Pin output in latch mode follows the latch.
  AST_PIN_LATCH: assert property (
    (s_q.output_control[CH_STRIDE+POS_PIN_SEL] && s_q.latched[1]) |=>
      pin_out[1])
    else $error("Pin output 1 does not show the latch.");

  // A read of the read/clear register returns live and latched states.
  AST_READ_STATE: assert property (
    rd_setup_rdc |=> prdata[POS_LIVE +: CH_N] == $past(live) &&
      prdata[POS_LATCHED +: CH_N] == $past(s_q.latched) &&
      prdata[31:8] == 24'h000000)
    else $error("Read/clear register returned wrong state.");

  // Latch 0 never falls while its lookup output is high.
  AST_LATCH_REPORT: assert property (
    $fell(s_q.latched[0]) |-> !$past(lut[0]))
    else $error("Latch 0 fell while its lookup output was high.");

  // Analog connection bits follow a write one cycle on.
  AST_ANALOG: assert property (
    (wr_acc && hit_out) |=>
      ana_cfg.analog_out_connect == {$past(pwdata[7]), $past(pwdata[3])})
    else $error("Analog connection does not follow the written value.");

  // Function codes follow a write.
  AST_CODE: assert property (
    (wr_acc && hit_fn) |=> s_q.function_select == $past(pwdata[7:0]))
    else $error("Function codes not updated by a write.");

  // A disabled comparator reads as low.
  AST_DISABLED: assert property (
    !ana_cfg.enable[1] |-> !rdc_view[POS_LIVE+1])
    else $error("Disabled comparator 1 reads high.");

  // Main scenarios worth seeing.
  COV_SET: cover property (!s_q.latched[0] ##1 s_q.latched[0]);
  COV_EDGE_CLEAR: cover property (
    s_q.output_control[POS_CLEAR_SEL] && rise[1] && s_q.latched[0]);
  COV_WRITE_CLEAR: cover property (wr0_clear && s_q.latched[0]);
  COV_READ: cover property (rd_setup_rdc ##1 psel && penable);

endmodule : dcl_unit
`default_nettype wire

//--- dcl_cmp_model.sv
// Behavioural model of the two analog comparators ahead of the unit.
`timescale 1ns/1ps
`default_nettype none
module dcl_cmp_model (
  input wire logic [dcl_pkg::CH_N-1:0] analog_level,
  input wire dcl_pkg::dcl_ana_cfg_t ana_cfg,
  output logic [dcl_pkg::CH_N-1:0] cmp_raw
);
  import dcl_pkg::*;

  // A switched-off comparator draws no power and its output rests low.
  always_comb begin
    cmp_raw = analog_level & ana_cfg.enable;
  end
endmodule : dcl_cmp_model
`default_nettype wire

//--- tb_dual_comparator_logic_unit.sv
// Self-checking testbench of the comparator logic unit.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_comparator_logic_unit;
  import dcl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] level = 2'h0;
  logic [1:0] cmp_raw;
  dcl_ana_cfg_t ana_cfg;
  logic [1:0] main_out;
  logic [1:0] pin_out;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int num_checks = 0;
  localparam logic [11:0] A_RC = {IDX_READ_CLEAR, 2'h0};
  localparam logic [11:0] A_IS = {IDX_INPUT_SELECT, 2'h0};
  localparam logic [11:0] A_EC = {IDX_ENABLE_CONTROL, 2'h0};
  localparam logic [11:0] A_OC = {IDX_OUTPUT_CONTROL, 2'h0};
  localparam logic [11:0] A_FS = {IDX_FUNCTION_SELECT, 2'h0};

  dcl_unit u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_raw(cmp_raw), .ana_cfg(ana_cfg), .main_out(main_out),
    .pin_out(pin_out));
  dcl_cmp_model u_cmp (.analog_level(level), .ana_cfg(ana_cfg),
    .cmp_raw(cmp_raw));

  // The clock toggles every half period of 25 ns.
  always #25 sys_clk = ~sys_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // One APB transfer, entered just after an edge; an idle edge follows.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      give_verdict();
    end
    @(posedge sys_clk);
  endtask : apb

  task automatic t_reset();
    logic [11:0] al [5] = '{A_RC, A_IS, A_EC, A_OC, A_FS};
    foreach (al[i]) begin
      apb(1'b0, al[i], 32'h0);
      chk("reset value", 32'h0, rd);
      chk("error flag", 32'h0, {31'h0, err});
    end
    apb(1'b1, 12'h200, 32'hff);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    apb(1'b1, A_IS, 32'ha5);
    apb(1'b1, A_EC, 32'h11);
    apb(1'b1, A_OC, 32'h80);
    apb(1'b1, A_FS, 32'h3c);
    // A write without the low byte strobe must leave the codes alone.
    pstrb <= 4'h0;
    apb(1'b1, A_FS, 32'h55);
    pstrb <= 4'hf;
    chk("analog config", 32'hea5, {20'h0, ana_cfg});
    apb(1'b0, A_EC, 32'h0);
    chk("enable reg", 32'h11, rd);
    apb(1'b0, A_FS, 32'h0);
    chk("function reg", 32'h3c, rd);
    apb(1'b0, A_IS, 32'h0);
    chk("input select reg", 32'ha5, rd);
    apb(1'b1, A_OC, 32'h0);
    $display("test registers done");
  endtask : t_regs

  // Every code and every input pair, in live mode.
  task automatic t_lut();
    logic [3:0] cd;
    logic [1:0] v;
    for (int c = 0; c < 16; c++) begin
      cd = c[3:0];
      apb(1'b1, A_FS, {24'h0, cd, cd});
      for (int k = 0; k < 4; k++) begin
        v = k[1:0];
        level <= v;
        repeat (5) @(posedge sys_clk);
        chk("main out", {30'h0, cd[{v[0], v[1]}], cd[v]},
          {30'h0, main_out});
        chk("pin out", {30'h0, cd[{v[0], v[1]}], cd[v]},
          {30'h0, pin_out});
        apb(1'b0, A_RC, 32'h0);
        chk("live bits", {30'h0, v}, {30'h0, rd[5:4]});
      end
    end
    apb(1'b1, A_EC, 32'h01);
    apb(1'b1, A_FS, 32'haa);
    level <= 2'h3;
    repeat (5) @(posedge sys_clk);
    chk("disabled channel", 32'h1, {30'h0, main_out});
    level <= 2'h0;
    apb(1'b1, A_EC, 32'h11);
    $display("test lookup done");
  endtask : t_lut

  task automatic t_latch();
    apb(1'b1, A_FS, 32'h22);
    apb(1'b1, A_OC, 32'h55);
    apb(1'b1, A_RC, 32'h0);
    level <= 2'h1;
    repeat (5) @(posedge sys_clk);
    level <= 2'h0;
    repeat (5) @(posedge sys_clk);
    chk("latched main", 32'h1, {30'h0, main_out});
    chk("latched pin", 32'h1, {30'h0, pin_out});
    apb(1'b0, A_RC, 32'h0);
    apb(1'b1, A_RC, 32'h33);
    apb(1'b0, A_RC, 32'h0);
    chk("latch after one", 32'h1, rd);
    // A one-cycle lookup pulse lands exactly on the clearing write edge.
    level <= 2'h1;
    @(posedge sys_clk);
    level <= 2'h0;
    apb(1'b1, A_RC, 32'h0);
    apb(1'b0, A_RC, 32'h0);
    chk("set beats clear", 32'h1, rd);
    apb(1'b1, A_RC, 32'h0);
    apb(1'b0, A_RC, 32'h0);
    chk("latch cleared", 32'h0, rd);
    chk("main cleared", 32'h0, {30'h0, main_out});
    $display("test latch done");
  endtask : t_latch

  task automatic t_edge();
    apb(1'b1, A_OC, 32'h77);
    level <= 2'h1;
    repeat (5) @(posedge sys_clk);
    level <= 2'h0;
    apb(1'b1, A_RC, 32'h0);
    apb(1'b0, A_RC, 32'h0);
    chk("write ignored", 32'h1, rd);
    level <= 2'h2;
    repeat (5) @(posedge sys_clk);
    chk("edge cleared", 32'h2, {30'h0, main_out});
    chk("edge pin", 32'h2, {30'h0, pin_out});
    level <= 2'h0;
    $display("test edge clear done");
  endtask : t_edge

  // Reset for 16 cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_lut();
    t_latch();
    t_edge();
    give_verdict();
  end
endmodule : tb_dual_comparator_logic_unit
`default_nettype wire
